/* File: verilog/kwu_defines.svh */
// register offsets, field positions and reset values of the keypad wake unit
`ifndef KWU_DEFINES_SVH
`define KWU_DEFINES_SVH
`define KWU_OFF_SC      4'h0
`define KWU_OFF_PE      4'h4
`define KWU_OFF_DATA    4'h8
`define KWU_OFF_DIR     4'hc
`define KWU_OFF_PULL    4'hc
`define KWU_SC_MODE     0
`define KWU_SC_IE       1
`define KWU_SC_ACK      2
`define KWU_SC_FLAG     3
`define KWU_SC_POL_LO   4
`define KWU_RST_BYTE    8'h00
`endif

/* File: verilog/kwu_pkg.sv */
// types of the keypad wake unit
package kwu_pkg;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull_en;
        logic [7:0] pull_dn;
    } kwu_pad_t;
endpackage : kwu_pkg

/* File: verilog/kwu_keypad_wake_unit.sv */
// keypad wake unit sharing an 8-bit port, with a classic wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "kwu_defines.svh"

// Behaviour
// - eight pin enable bits pick any set of port lines as key inputs
// - lines enabled as key inputs are forced to inputs
// - other lines stay plain port pins under data, direction, pull
// - mode bit selects edge-only or edge-and-level detection
// - lines 3..0 sense falling edges or low levels only
// - lines 7..4 have a polarity bit each
// - pull enable gives pulldown on upper key lines set for rising
// - enabled key event raises a wake request for wait and standby when interrupt enable is one
// - one common flag and one interrupt enable for all lines
// - edge seen as one bus cycle deasserted, next cycle asserted
// - writing one to acknowledge clears flag; acknowledge reads zero
// - in edge-and-level mode flag holds while any enabled key line is asserted
// - interrupt request follows flag when interrupt enable is one
module kwu_keypad_wake_unit
    import kwu_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output var  logic [31:0] dat_o,
    output var  logic        ack_o,
    // port pins
    input  wire logic [7:0]  pin_i,
    output var  kwu_pad_t    pad_o,
    // events
    output var  logic        irq_o,
    output var  logic        wake_o
);
    // control and port registers
    logic [7:0]  pe_q;       // key pin enables
    logic [7:0]  pol_q;      // upper nibble polarity, 1 = rising/high
    logic [7:0]  dat_q;      // port output data
    logic [7:0]  dir_q;      // port direction, 1 = drive
    logic [7:0]  pull_q;     // port pull enables
    logic        mode_q;     // 1 = edge and level
    logic        ie_q;       // interrupt enable
    logic        flag_q;     // common key event flag
    logic        ack_q;      // bus answer pending
    // synchroniser and edge history
    logic [7:0]  s1_q;
    logic [7:0]  s2_q;
    logic [7:0]  act_prev_q;
    logic [31:0] rd_d;

    function automatic logic [7:0] kwu_asserted(input logic [7:0] lvl,
                                                input logic [7:0] pol,
                                                input logic [7:0] en);
        kwu_asserted = (lvl ~^ {pol[7:4], 4'h0}) & en;
    endfunction : kwu_asserted

    // bus decode
    // a write lands only on the taking edge, never in the ack cycle
    wire        wr_req  = cyc_i & stb_i & we_i & ~ack_q & sel_i[0];
    wire        rd_req  = cyc_i & stb_i & ~ack_q;
    wire        hit_sc  = (adr_i == `KWU_OFF_SC);
    wire        hit_pe  = (adr_i == `KWU_OFF_PE);
    wire        hit_dat = (adr_i == `KWU_OFF_DATA);
    wire        hit_dir = (adr_i == `KWU_OFF_DIR);
    wire        ack_hit = wr_req & hit_sc & dat_i[`KWU_SC_ACK];

    // synchronised levels and edge detection
    // enabling a line that already sits asserted counts as an edge
    wire [7:0]  act_now = kwu_asserted(s2_q, pol_q, pe_q);
    wire [7:0]  edge_w  = act_now & ~act_prev_q & pe_q;
    wire        lvl_any = mode_q & (|act_now);
    wire        set_w   = (|edge_w) | lvl_any;

    // two-flop synchroniser per pin
    always_ff @(posedge clk_i) begin
        s1_q <= pin_i;
        s2_q <= s1_q;
        if (rst_i) begin
            act_prev_q <= `KWU_RST_BYTE;
        end else begin
            act_prev_q <= act_now;
        end
    end

    // common flag: set wins over acknowledge
    // in edge-and-level mode a held line sets the flag every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (set_w) begin
            flag_q <= 1'b1;
        end else if (ack_hit) begin
            flag_q <= 1'b0;
        end
    end

    // register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pe_q   <= `KWU_RST_BYTE;
            pol_q  <= `KWU_RST_BYTE;
            mode_q <= 1'b0;
            ie_q   <= 1'b0;
            dat_q  <= `KWU_RST_BYTE;
            dir_q  <= `KWU_RST_BYTE;
            pull_q <= `KWU_RST_BYTE;
        end else if (wr_req) begin
            if (hit_sc) begin
                pol_q[7:4] <= dat_i[7:4];
                ie_q       <= dat_i[`KWU_SC_IE];
                mode_q     <= dat_i[`KWU_SC_MODE];
            end else if (hit_pe) begin
                pe_q <= dat_i[7:0];
            end else if (hit_dat) begin
                dat_q <= dat_i[7:0];
            end else if (hit_dir) begin
                dir_q  <= dat_i[7:0];
                pull_q <= dat_i[15:8];
            end
        end
    end

    // read data mux; acknowledge bit reads zero
    always_comb begin
        rd_d = 32'h0;
        if (hit_sc) begin
            rd_d[7:0] = {pol_q[7:4], flag_q, 1'b0, ie_q, mode_q};
        end else if (hit_pe) begin
            rd_d[7:0] = pe_q;
        end else if (hit_dat) begin
            rd_d[7:0] = s2_q;
        end else if (hit_dir) begin
            rd_d[15:0] = {pull_q, dir_q};
        end
    end

    // bus answer, one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_q <= rd_req;
            dat_o <= rd_req ? rd_d : 32'h0;
        end
    end
    assign ack_o = ack_q;

    // pad control, interrupt and wake outputs
    // key lines lose their drive; pulls flip for rising upper keys
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_o  <= '0;
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            pad_o.out     <= dat_q;
            pad_o.oe      <= dir_q & ~pe_q;
            pad_o.pull_en <= pull_q & ~(dir_q & ~pe_q);
            pad_o.pull_dn <= {pe_q[7:4] & pol_q[7:4], 4'h0};
            irq_o  <= flag_q & ie_q;
            wake_o <= flag_q & ie_q;
        end
    end

    // checks on the flag, the bus answer and the pad control
    a_edge_sets_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (|edge_w) |=> flag_q) else $error("edge did not set flag");
    a_ack_clears: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ack_hit && !set_w) |=> !flag_q) else $error("ack left flag");
    a_level_holds: assert property (
        @(posedge clk_i) disable iff (rst_i)
        lvl_any |=> flag_q) else $error("level did not hold flag");
    a_irq_follows: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_o == $past(flag_q & ie_q)) else $error("irq mismatch");
    a_key_is_input: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 (pad_o.oe & $past(pe_q)) == 8'h0) else $error("key line driven");
    a_low_no_pulldn: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pad_o.pull_dn[3:0] == 4'h0) else $error("low nibble pulldown");
    a_ack_reads_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ack_o && $past(hit_sc)) |-> !dat_o[`KWU_SC_ACK])
        else $error("ack read one");
    a_reset_clear: assert property (
        @(posedge clk_i)
        $past(rst_i) |-> (pe_q == 8'h0 && !flag_q && !ie_q && !mode_q))
        else $error("reset left state");
    a_wake_follows: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (flag_q && ie_q) |=> wake_o) else $error("no wake");
    a_flag_has_cause: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(flag_q) |-> $past(set_w)) else $error("flag set without event");
    a_upper_pulldn: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pad_o.pull_dn[7:4] == $past(pe_q[7:4] & pol_q[7:4]))
        else $error("upper pulldown wrong");
    a_sync_depth: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s2_q == $past(pin_i, 2)) else $error("synchroniser depth wrong");

    // cover points for the main scenarios
    c_edge_flag: cover property (@(posedge clk_i) disable iff (rst_i)
        |edge_w ##1 flag_q);
    c_ack_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        ack_hit ##1 !flag_q);
    c_level_held: cover property (@(posedge clk_i) disable iff (rst_i)
        ack_hit && lvl_any);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i)
        irq_o);
    c_rise_key: cover property (@(posedge clk_i) disable iff (rst_i)
        |(edge_w[7:4] & pol_q[7:4]));
endmodule : kwu_keypad_wake_unit
`default_nettype wire

/* File: test/kwu_keypad_model.sv */
// keypad switches and pull devices on the shared port lines
`timescale 1ns/1ps
`default_nettype none
module kwu_keypad_model
    import kwu_pkg::*;
(
    input  wire logic       clk_i,
    input  wire kwu_pad_t   pad_i,
    input  wire logic [7:0] press_i,
    input  wire logic [7:0] level_i,
    output var  logic [7:0] pin_o
);
    logic flt_q = 1'b0;
    // a line nobody drives or pulls wanders every cycle
    always_ff @(posedge clk_i) flt_q <= ~flt_q;
    // port drive wins, then a closed switch, then the pull device
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_i.oe[i]) pin_o[i] = pad_i.out[i];
            else if (press_i[i]) pin_o[i] = level_i[i];
            else if (pad_i.pull_en[i]) pin_o[i] = ~pad_i.pull_dn[i];
            else pin_o[i] = flt_q;
        end
    end
endmodule : kwu_keypad_model
`default_nettype wire

/* File: test/kwu_keypad_wake_unit_test.sv */
// self-checking bench of the keypad wake unit
`timescale 1ns/1ps
`default_nettype none
module kwu_keypad_wake_unit_test;
    import kwu_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'hf;
    logic [3:0]  wsel = 4'hf;
    logic [7:0]  press = 8'h00;
    logic [7:0]  level = 8'h00;
    logic [31:0] lfsr = 32'h9c11;
    logic [31:0] dat;
    logic        ack, irq, wake;
    logic [7:0]  pin;
    kwu_pad_t    pad;
    logic [7:0]  expq[$];
    int          num_errors = 0;
    int          n_checks = 0;
    kwu_keypad_wake_unit kwu_keypad_wake_unit_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(dat), .ack_o(ack), .pin_i(pin), .pad_o(pad),
        .irq_o(irq), .wake_o(wake));
    kwu_keypad_model kwu_keypad_model_i (.clk_i(clk_i), .pad_i(pad),
        .press_i(press), .level_i(level), .pin_o(pin));
    initial forever #10 clk_i = ~clk_i;
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0, d};
        sel <= wsel;
        do @(posedge clk_i); while (ack !== 1'b1);
        req <= 1'b0;
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        expq.push_back(e);
        wb(1'b0, a, 16'h0);
    endtask : rd
    // read data against the oldest noted expectation
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            chk("read data", dat[7:0], expq.pop_front());
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        chk("pad", pad, 32'h0);
        wb(1'b1, 4'hc, 16'hffff);
        for (int i = 0; i < 4; i++) begin
            lfsr = next_rand(lfsr);
            wb(1'b1, 4'h8, lfsr[15:0]);
            @(posedge clk_i);
            chk("pad out", pad.out, lfsr[7:0]);
        end
        rd(4'h8, lfsr[7:0]);
        wb(1'b1, 4'h4, 16'h81);
        @(posedge clk_i);
        chk("pad oe", pad.oe, 8'h7e);
        chk("pad pull", pad.pull_en, 8'h81);
        wb(1'b1, 4'h0, 16'h82);
        @(posedge clk_i);
        chk("pad pulldown", pad.pull_dn, 8'h80);
        // clear what the set-up itself flagged before the key tests
        wb(1'b1, 4'h0, 16'h86);
        rd(4'h0, 8'h82);
        // low key on line 0, then high key on line 7, edge mode
        for (int k = 0; k < 2; k++) begin
            press <= k ? 8'h80 : 8'h01;
            level <= k ? 8'h80 : 8'h00;
            repeat (4) @(posedge clk_i);
            rd(4'h0, 8'h8a);
            chk("irq wake", {irq, wake}, 2'b11);
            wb(1'b1, 4'h0, 16'h86);
            rd(4'h0, 8'h82);
            press <= 8'h00;
            repeat (4) @(posedge clk_i);
        end
        // edge-and-level mode: held key keeps the flag
        wb(1'b1, 4'h0, 16'h81);
        press <= 8'h01;
        level <= 8'h00;
        repeat (4) @(posedge clk_i);
        wb(1'b1, 4'h0, 16'h85);
        rd(4'h0, 8'h89);
        chk("irq wake", {irq, wake}, 2'b00);
        press <= 8'h00;
        repeat (4) @(posedge clk_i);
        wb(1'b1, 4'h0, 16'h85);
        rd(4'h0, 8'h81);
        rd(4'h2, 8'h00);
        // a write without the low byte lane is ignored
        wsel = 4'he;
        wb(1'b1, 4'h4, 16'h00ff);
        wsel = 4'hf;
        rd(4'h4, 8'h81);
        give_verdict();
    end
endmodule : kwu_keypad_wake_unit_test
`default_nettype wire
